/* File: hw/hss_sequencer.sv */
// Homing search sequencer: picks a pattern from the method code and
// steers drive direction and speed until the home point is reached.
// Assumes controlword, method and speeds are synchronous to sys_clk.
`timescale 1ns/1ns
module hss_sequencer #(
    parameter int SPEED_W = hss_pkg::SPEED_W
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          nrst,
    // Host command
    input  wire logic [hss_pkg::CW_W-1:0]      controlWord,
    input  wire logic [hss_pkg::METHOD_W-1:0]  homingMethod,
    input  wire logic [SPEED_W-1:0]            highSpeed,
    input  wire logic [SPEED_W-1:0]            lowSpeed,
    // Sensors
    input  wire logic                          homeReferenceSwitch,
    input  wire logic                          posLimit,
    input  wire logic                          negLimit,
    input  wire logic                          encIndex,
    // Drive command
    output hss_pkg::hss_drive_t                driveCmd_q,
    output logic [SPEED_W-1:0]                 speedCmd_q,
    // Status
    output logic                               homeBusy_q,
    output logic                               homeDone_q,
    output logic                               methodErr_q
);

    logic [hss_pkg::IN_W-1:0]     inLevel;
    logic [hss_pkg::IN_W-1:0]     inRise;
    logic [hss_pkg::IN_W-1:0]     inFall;
    logic [hss_pkg::CW_W-1:0]     cwPrev_q;
    hss_pkg::hss_state_t          state_q;
    hss_pkg::hss_method_t         method_q;
    logic [hss_pkg::METHOD_W-1:0] methodCode_q;
    logic                         limitSeen_q;
    hss_pkg::hss_method_t         info;
    logic                         startReq;
    logic                         runEnabled;
    logic                         homeRise;
    logic                         homeFall;
    logic                         limitAhead;

    hss_edge_sync #(
        .WIDTH (hss_pkg::IN_W)
    ) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .rawIn   ({encIndex, negLimit, posLimit, homeReferenceSwitch}),
        .level   (inLevel),
        .rise    (inRise),
        .fall    (inFall)
    );

    assign info       = hss_pkg::methodLookup(homingMethod);
    assign runEnabled = &(controlWord[3:0] & hss_pkg::CW_RUN_MSK);
    assign startReq   = (cwPrev_q == hss_pkg::CW_READY)
                     && (controlWord == hss_pkg::CW_TRIGGER)
                     && !homeBusy_q;
    assign homeRise   = inRise[hss_pkg::IN_HOME];
    assign homeFall   = inFall[hss_pkg::IN_HOME];
    assign limitAhead = driveCmd_q.neg ? inLevel[hss_pkg::IN_NLIM]
                                       : inLevel[hss_pkg::IN_PLIM];

    // Previous controlword
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cwPrev_q <= '0;
        end else begin
            cwPrev_q <= controlWord;
        end
    end

    // Search sequence
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q      <= hss_pkg::S_IDLE;
            driveCmd_q   <= '0;
            method_q     <= '0;
            methodCode_q <= '0;
            limitSeen_q  <= 1'b0;
            homeBusy_q   <= 1'b0;
            homeDone_q   <= 1'b0;
            methodErr_q  <= 1'b0;
        end else if (startReq) begin
            method_q     <= info;
            methodCode_q <= homingMethod;
            limitSeen_q  <= 1'b0;
            homeDone_q   <= 1'b0;
            methodErr_q  <= !info.valid;
            if (!info.valid) begin
                state_q    <= hss_pkg::S_IDLE;
                driveCmd_q <= '0;
                homeBusy_q <= 1'b0;
            end else begin
                unique case (info.kind)
                    hss_pkg::K_HERE: begin
                        state_q    <= hss_pkg::S_DONE;
                        driveCmd_q <= '0;
                        homeBusy_q <= 1'b0;
                        homeDone_q <= 1'b1;
                    end
                    hss_pkg::K_INDEX: begin
                        state_q    <= hss_pkg::S_INDEX;
                        driveCmd_q <= '{1'b1, info.baseNeg, 1'b0};
                        homeBusy_q <= 1'b1;
                    end
                    default: begin
                        homeBusy_q <= 1'b1;
                        if (inLevel[hss_pkg::IN_HOME]) begin
                            state_q    <= hss_pkg::S_SLOW1;
                            driveCmd_q <= '{1'b1, info.slowNeg, 1'b0};
                        end else begin
                            state_q    <= hss_pkg::S_FAST;
                            driveCmd_q <= '{1'b1, info.baseNeg, 1'b1};
                        end
                    end
                endcase
            end
        end else if (homeBusy_q && !runEnabled) begin
            state_q    <= hss_pkg::S_IDLE;
            driveCmd_q <= '0;
            homeBusy_q <= 1'b0;
        end else begin
            unique case (state_q)
                hss_pkg::S_FAST: begin
                    if (homeRise) begin
                        state_q    <= hss_pkg::S_SLOW1;
                        driveCmd_q <= '{1'b1, method_q.slowNeg, 1'b0};
                    end else if (limitAhead && !limitSeen_q) begin
                        limitSeen_q    <= 1'b1;
                        driveCmd_q.neg <= !driveCmd_q.neg;
                    end
                end
                hss_pkg::S_SLOW1: begin
                    if (homeFall) begin
                        if (method_q.stopAtFall) begin
                            state_q    <= hss_pkg::S_DONE;
                            driveCmd_q <= '0;
                            homeBusy_q <= 1'b0;
                            homeDone_q <= 1'b1;
                        end else begin
                            state_q    <= hss_pkg::S_SLOW2;
                            driveCmd_q <= '{1'b1, method_q.finalNeg, 1'b0};
                        end
                    end
                end
                hss_pkg::S_SLOW2: begin
                    if (homeRise) begin
                        state_q    <= hss_pkg::S_DONE;
                        driveCmd_q <= '0;
                        homeBusy_q <= 1'b0;
                        homeDone_q <= 1'b1;
                    end
                end
                hss_pkg::S_INDEX: begin
                    if (inRise[hss_pkg::IN_INDEX]) begin
                        state_q    <= hss_pkg::S_DONE;
                        driveCmd_q <= '0;
                        homeBusy_q <= 1'b0;
                        homeDone_q <= 1'b1;
                    end
                end
                hss_pkg::S_IDLE, hss_pkg::S_DONE: begin
                    state_q <= state_q;
                end
                default: begin
                    state_q    <= hss_pkg::S_IDLE;
                    driveCmd_q <= '0;
                    homeBusy_q <= 1'b0;
                end
            endcase
        end
    end

    // Speed command follows the drive command one cycle later
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            speedCmd_q <= '0;
        end else if (!driveCmd_q.run) begin
            speedCmd_q <= '0;
        end else if (driveCmd_q.fast) begin
            speedCmd_q <= highSpeed;
        end else begin
            speedCmd_q <= lowSpeed;
        end
    end

    // Start with switch inactive goes fast in base direction
    property p_start_fast;
        @(posedge sys_clk) disable iff (!nrst)
        (startReq && info.valid && info.kind == hss_pkg::K_SWITCH
         && !inLevel[hss_pkg::IN_HOME])
        |=> (state_q == hss_pkg::S_FAST) && driveCmd_q.fast && driveCmd_q.run
            && (driveCmd_q.neg == $past(info.baseNeg));
    endproperty
    a_start_fast: assert property (p_start_fast) else $error("fast start wrong");

    // Start with switch active goes slow at once
    property p_start_slow;
        @(posedge sys_clk) disable iff (!nrst)
        (startReq && info.valid && info.kind == hss_pkg::K_SWITCH
         && inLevel[hss_pkg::IN_HOME])
        |=> driveCmd_q.run && !driveCmd_q.fast && (state_q == hss_pkg::S_SLOW1);
    endproperty
    a_start_slow: assert property (p_start_slow) else $error("slow start wrong");

    // First limit in search direction reverses at high speed
    property p_limit_reverse;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_FAST && limitAhead && !limitSeen_q && !homeRise
         && !startReq && runEnabled)
        |=> (driveCmd_q.neg != $past(driveCmd_q.neg)) && driveCmd_q.fast;
    endproperty
    a_limit_reverse: assert property (p_limit_reverse) else $error("no reversal");

    // Method 24 turns negative slow at switch rise
    property p_m24_rise;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_FAST && methodCode_q == hss_pkg::M_24 && homeRise
         && !startReq && runEnabled)
        |=> driveCmd_q.neg && !driveCmd_q.fast ##1 speedCmd_q == $past(lowSpeed);
    endproperty
    a_m24_rise: assert property (p_m24_rise) else $error("m24 rise wrong");

    // Method 26 stops at switch fall
    property p_m26_fall;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_SLOW1 && methodCode_q == hss_pkg::M_26 && homeFall
         && runEnabled)
        |=> homeDone_q && !driveCmd_q.run;
    endproperty
    a_m26_fall: assert property (p_m26_fall) else $error("m26 no stop");

    // Method 28 turns negative slow at switch fall
    property p_m28_fall;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_SLOW1 && methodCode_q == hss_pkg::M_28 && homeFall
         && runEnabled)
        |=> (state_q == hss_pkg::S_SLOW2) && driveCmd_q.neg && !homeDone_q;
    endproperty
    a_m28_fall: assert property (p_m28_fall) else $error("m28 fall wrong");

    // Method 33 runs negative slow
    property p_m33_start;
        @(posedge sys_clk) disable iff (!nrst)
        (startReq && homingMethod == hss_pkg::M_33)
        |=> driveCmd_q.run && driveCmd_q.neg && !driveCmd_q.fast && homeBusy_q;
    endproperty
    a_m33_start: assert property (p_m33_start) else $error("m33 start wrong");

    // Method 35 is done with no motion
    property p_m35_here;
        @(posedge sys_clk) disable iff (!nrst)
        (startReq && homingMethod == hss_pkg::M_35)
        |=> (homeDone_q && !driveCmd_q.run) [*2];
    endproperty
    a_m35_here: assert property (p_m35_here) else $error("m35 moved");

    // Only the controlword transition starts a search
    property p_trigger;
        @(posedge sys_clk) disable iff (!nrst)
        (!homeBusy_q && $rose(homeBusy_q) == 1'b0 && !startReq) |=> !$rose(homeBusy_q);
    endproperty
    a_trigger: assert property (p_trigger) else $error("start without trigger");

    // Dropping run bits stops motion
    property p_abort;
        @(posedge sys_clk) disable iff (!nrst)
        (homeBusy_q && !runEnabled && !startReq) |=> !driveCmd_q.run ##1 speedCmd_q == '0;
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");

    // Method 26 keeps positive slow at rise
    property p_m26_rise;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_FAST && methodCode_q == hss_pkg::M_26 && homeRise
         && runEnabled)
        |=> driveCmd_q.run && !driveCmd_q.neg && !driveCmd_q.fast;
    endproperty
    a_m26_rise: assert property (p_m26_rise) else $error("m26 rise wrong");

    // Method 29 turns positive slow at fall
    property p_m29_fall;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_SLOW1 && methodCode_q == hss_pkg::M_29 && homeFall
         && runEnabled)
        |=> (state_q == hss_pkg::S_SLOW2) && driveCmd_q.run && !driveCmd_q.neg;
    endproperty
    a_m29_fall: assert property (p_m29_fall) else $error("m29 fall wrong");

    // Method 30 stops at fall
    property p_m30_fall;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_SLOW1 && methodCode_q == hss_pkg::M_30 && homeFall
         && runEnabled)
        |=> homeDone_q && !homeBusy_q && !driveCmd_q.run;
    endproperty
    a_m30_fall: assert property (p_m30_fall) else $error("m30 no stop");

    // Second slow phase stops at rise
    property p_slow2_stop;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_SLOW2 && homeRise && runEnabled)
        |=> homeDone_q && !driveCmd_q.run;
    endproperty
    a_slow2_stop: assert property (p_slow2_stop) else $error("slow2 no stop");

    // Method 34 runs positive slow
    property p_m34_start;
        @(posedge sys_clk) disable iff (!nrst)
        (startReq && homingMethod == hss_pkg::M_34)
        |=> driveCmd_q.run && !driveCmd_q.neg && !driveCmd_q.fast;
    endproperty
    a_m34_start: assert property (p_m34_start) else $error("m34 start wrong");

    // Index search stops at index rise
    property p_index_stop;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == hss_pkg::S_INDEX && inRise[hss_pkg::IN_INDEX] && runEnabled)
        |=> homeDone_q && !driveCmd_q.run;
    endproperty
    a_index_stop: assert property (p_index_stop) else $error("index no stop");

    // Fast phase drives the high speed
    property p_fast_speed;
        @(posedge sys_clk) disable iff (!nrst)
        (driveCmd_q.run && driveCmd_q.fast) |=> speedCmd_q == $past(highSpeed);
    endproperty
    a_fast_speed: assert property (p_fast_speed) else $error("fast speed wrong");

    // Done only while stopped
    property p_done_still;
        @(posedge sys_clk) disable iff (!nrst)
        homeDone_q |-> !driveCmd_q.run && !homeBusy_q;
    endproperty
    a_done_still: assert property (p_done_still) else $error("done while moving");


    c_m24_done: cover property (@(posedge sys_clk) disable iff (!nrst)
        methodCode_q == hss_pkg::M_24 && $rose(homeDone_q));
    c_limit: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(limitSeen_q));
    c_index: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_q == hss_pkg::S_INDEX ##1 state_q == hss_pkg::S_DONE);
    c_abort: cover property (@(posedge sys_clk) disable iff (!nrst)
        $fell(homeBusy_q) && !homeDone_q);
    c_fall_stop: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_q == hss_pkg::S_SLOW1 ##1 state_q == hss_pkg::S_DONE);

endmodule

/* File: hw/hss_pkg.sv */
// Constants, types and method table of the homing search sequencer.
// Assumes one drive clock; host inputs are synchronous to it, sensor inputs are synchronised to it.
// What this block does
// - Method code selects pattern; home switch decides
// - Sample switch at start: fast or slow
// - 24 inactive: pos fast, neg slow, pos slow
// - 24 limit: neg fast, neg slow, pos slow
// - 24 active: neg slow, then pos slow
// - 26 inactive: pos fast, then pos slow
// - 26 limit: neg fast, pos slow, stop falling
// - 26 active: pos slow at once
// - 28 inactive: neg fast, pos slow, neg slow
// - 28 limit: pos fast, pos slow, neg slow
// - 28 active: pos slow, then neg slow
// - 29 inactive: neg fast, neg slow, pos slow
// - 29 limit: pos fast, neg slow, pos slow
// - 29 active: neg slow, pos slow, stop rising
// - 30 inactive: neg fast, neg slow, stop falling
// - 30 limit: pos fast, neg slow, stop falling
// - 30 active: neg slow, stop falling
// - First limit during fast search reverses, keeps fast
// - 33: neg slow, stop at index pulse
// - 34: pos slow, stop at index pulse
// - 35: current position is home, no motion
package hss_pkg;

    localparam int          CW_W       = 16;
    localparam int          METHOD_W   = 8;
    localparam int          SPEED_W    = 32;
    localparam logic [15:0] CW_READY   = 16'h000F;
    localparam logic [15:0] CW_TRIGGER = 16'h001F;
    localparam logic [3:0]  CW_RUN_MSK = 4'hF;

    // Input bit positions on the synchroniser
    localparam int IN_W     = 4;
    localparam int IN_HOME  = 0;
    localparam int IN_PLIM  = 1;
    localparam int IN_NLIM  = 2;
    localparam int IN_INDEX = 3;

    localparam logic [7:0] M_24 = 8'h18;
    localparam logic [7:0] M_26 = 8'h1A;
    localparam logic [7:0] M_28 = 8'h1C;
    localparam logic [7:0] M_29 = 8'h1D;
    localparam logic [7:0] M_30 = 8'h1E;
    localparam logic [7:0] M_33 = 8'h21;
    localparam logic [7:0] M_34 = 8'h22;
    localparam logic [7:0] M_35 = 8'h23;

    typedef enum logic [1:0] {
        K_SWITCH = 2'h0,
        K_INDEX  = 2'h1,
        K_HERE   = 2'h2
    } hss_kind_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_FAST  = 3'h1,
        S_SLOW1 = 3'h2,
        S_SLOW2 = 3'h3,
        S_INDEX = 3'h4,
        S_DONE  = 3'h5
    } hss_state_t;

    // Pattern of one method
    typedef struct packed {
        logic      valid;
        hss_kind_t kind;
        logic      baseNeg;
        logic      slowNeg;
        logic      stopAtFall;
        logic      finalNeg;
    } hss_method_t;

    // Drive command
    typedef struct packed {
        logic run;
        logic neg;
        logic fast;
    } hss_drive_t;

    function automatic hss_method_t methodLookup(input logic [7:0] code);
        hss_method_t m;
        m = '{1'b0, K_SWITCH, 1'b0, 1'b0, 1'b0, 1'b0};
        unique case (code)
            M_24: m = '{1'b1, K_SWITCH, 1'b0, 1'b1, 1'b0, 1'b0};
            M_26: m = '{1'b1, K_SWITCH, 1'b0, 1'b0, 1'b1, 1'b0};
            M_28: m = '{1'b1, K_SWITCH, 1'b1, 1'b0, 1'b0, 1'b1};
            M_29: m = '{1'b1, K_SWITCH, 1'b1, 1'b1, 1'b0, 1'b0};
            M_30: m = '{1'b1, K_SWITCH, 1'b1, 1'b1, 1'b1, 1'b0};
            M_33: m = '{1'b1, K_INDEX,  1'b1, 1'b1, 1'b0, 1'b1};
            M_34: m = '{1'b1, K_INDEX,  1'b0, 1'b0, 1'b0, 1'b0};
            M_35: m = '{1'b1, K_HERE,   1'b0, 1'b0, 1'b0, 1'b0};
            default: m = '{1'b0, K_SWITCH, 1'b0, 1'b0, 1'b0, 1'b0};
        endcase
        return m;
    endfunction

endpackage

/* File: hw/hss_edge_sync.sv */
// Two-stage synchroniser with edge detect for a group of inputs.
// Assumes the raw inputs may be asynchronous to sys_clk.
`timescale 1ns/1ns
module hss_edge_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Raw inputs
    input  wire logic [WIDTH-1:0] rawIn,
    // Clean level and edges
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    // Metastability stage read only by sync stage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= rawIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;

endmodule

/* File: dv/hss_axis_model.sv */
// Behavioural axis: position, home switch, travel limits, index pulse.
// Assumes the sequencer's drive command; the bench presets the position.
`timescale 1ns/1ns
module hss_axis_model #(
    parameter int HOME_LO = 500,
    parameter int HOME_HI = 540,
    parameter int NLIM    = 100,
    parameter int PLIM    = 900,
    parameter int IDX     = 16
) (
    // Clock
    input  wire logic                sys_clk,
    // Drive and preset
    input  wire hss_pkg::hss_drive_t driveCmd,
    input  wire logic                loadEn,
    input  wire logic [15:0]         loadPos,
    // Sensors
    output logic                     homeReferenceSwitch,
    output logic                     posLimit,
    output logic                     negLimit,
    output logic                     encIndex
);
    int                  pos = 600;
    int                  step;
    hss_pkg::hss_drive_t d;
    logic                ld;
    logic [15:0]         lp;

    // Sample at the edge, move just after it
    always @(posedge sys_clk) begin
        d = driveCmd;
        ld = loadEn;
        lp = loadPos;
        #1;
        step = d.fast ? 4 : 1;
        if (ld)
            pos = int'(lp);
        else if (d.run)
            pos = d.neg ? pos - step : pos + step;
    end

    assign homeReferenceSwitch = (pos >= HOME_LO) && (pos <= HOME_HI);
    assign posLimit            = pos >= PLIM;
    assign negLimit            = pos <= NLIM;
    assign encIndex            = (pos % IDX) == 0;
endmodule

/* File: dv/hss_sequencer_tb_top.sv */
// Self-checking bench of the homing search sequencer.
// Assumes the axis model on the sensor side and a host on the controlword.
`timescale 1ns/1ns
module hss_sequencer_tb_top;
    localparam int DLY = 1;
    logic                sys_clk      = 1'h0;
    logic                nrst         = 1'h0;
    logic [15:0]         controlWord  = 16'h0000;
    logic [7:0]          homingMethod = 8'h00;
    logic [31:0]         highSpeed    = 32'h0;
    logic [31:0]         lowSpeed     = 32'h0;
    logic                loadEn       = 1'h0;
    logic [15:0]         loadPos      = 16'h0258;
    logic                homeRef;
    logic                posLim;
    logic                negLim;
    logic                encIdx;
    hss_pkg::hss_drive_t driveCmd;
    hss_pkg::hss_drive_t prevCmd      = '0;
    logic [31:0]         speedCmd;
    logic                busy;
    logic                done;
    logic                mErr;
    logic [7:0]          codes[8];
    logic [7:0]          m;
    bit                  act;
    bit                  lim;
    int                  badCount     = 0;
    int                  nCompared    = 0;

    always #25 sys_clk = ~sys_clk;

    hss_sequencer dut (
        .sys_clk(sys_clk), .nrst(nrst), .controlWord(controlWord),
        .homingMethod(homingMethod), .highSpeed(highSpeed), .lowSpeed(lowSpeed),
        .homeReferenceSwitch(homeRef), .posLimit(posLim), .negLimit(negLim),
        .encIndex(encIdx), .driveCmd_q(driveCmd), .speedCmd_q(speedCmd),
        .homeBusy_q(busy), .homeDone_q(done), .methodErr_q(mErr)
    );

    hss_axis_model axis (
        .sys_clk(sys_clk), .driveCmd(driveCmd), .loadEn(loadEn), .loadPos(loadPos),
        .homeReferenceSwitch(homeRef), .posLimit(posLim), .negLimit(negLim),
        .encIndex(encIdx)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic endOfTest();
        $display("compared %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Speed follows the previous cycle's drive command
    always @(negedge sys_clk) begin
        if (nrst)
            check(speedCmd, !prevCmd.run ? 32'h0 : (prevCmd.fast ? highSpeed : lowSpeed));
        prevCmd = nrst ? driveCmd : '0;
    end

    // Expected run-phase commands: base, limit, slow1, slow2
    function automatic int expSeq(input logic [7:0] mc, input bit a, input bit l,
                                  output hss_pkg::hss_drive_t e[4]);
        bit b;
        bit s1;
        bit sf;
        int n;
        n = 0;
        e = '{default: '0};
        case (mc)
            hss_pkg::M_24: {b, s1, sf} = 3'h2;
            hss_pkg::M_26: {b, s1, sf} = 3'h1;
            hss_pkg::M_28: {b, s1, sf} = 3'h4;
            hss_pkg::M_29: {b, s1, sf} = 3'h6;
            hss_pkg::M_30: {b, s1, sf} = 3'h7;
            hss_pkg::M_33: {b, s1, sf} = 3'h7;
            hss_pkg::M_34: {b, s1, sf} = 3'h1;
            default: return 0;
        endcase
        if (!a && mc < hss_pkg::M_33) begin
            e[n] = '{1'h1, b, 1'h1};
            n++;
            if (l) begin
                e[n] = '{1'h1, !b, 1'h1};
                n++;
            end
        end
        e[n] = '{1'h1, s1, 1'h0};
        n++;
        if (!sf) begin
            e[n] = '{1'h1, !s1, 1'h0};
            n++;
        end
        return n;
    endfunction

    // Start inside the window, or on the side that makes the limit hit or not
    function automatic logic [15:0] startPos(input logic [7:0] mc, input bit a, input bit l);
        int p;
        bit b;
        b = mc == hss_pkg::M_28 || mc == hss_pkg::M_29 || mc == hss_pkg::M_30
            || mc == hss_pkg::M_33;
        if (a)
            p = 505 + $urandom % 31;
        else if (b == l)
            p = 150 + $urandom % 300;
        else
            p = 600 + $urandom % 250;
        if (p % 16 == 0)
            p++;
        return 16'(p);
    endfunction

    task automatic startRun(input logic [7:0] mc);
        @(posedge sys_clk) #DLY;
        homingMethod = mc;
        controlWord = hss_pkg::CW_READY;
        @(posedge sys_clk) #DLY;
        controlWord = hss_pkg::CW_TRIGGER;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic runCase(input logic [7:0] mc, input bit a, input bit l);
        hss_pkg::hss_drive_t e[4];
        hss_pkg::hss_drive_t seen[8];
        int                  nExp;
        int                  n;
        int                  k;
        nExp = expSeq(mc, a, l, e);
        @(posedge sys_clk) #DLY;
        loadEn = 1'h1;
        loadPos = startPos(mc, a, l);
        highSpeed = $urandom;
        lowSpeed = $urandom;
        @(posedge sys_clk) #DLY;
        loadEn = 1'h0;
        repeat (4) @(posedge sys_clk);
        startRun(mc);
        check(32'(mErr), 32'h0);
        n = 0;
        k = 0;
        while (busy === 1'h1 && k < 20000) begin
            if (driveCmd.run === 1'h1 && n < 8 && (n == 0 || driveCmd !== seen[n-1])) begin
                seen[n] = driveCmd;
                n++;
            end
            @(negedge sys_clk);
            k++;
        end
        if (k >= 20000) begin
            badCount++;
            $display("[ERR] t=%0t search hung, busy=%0h exp=0", $time, busy);
            endOfTest();
        end
        @(negedge sys_clk);
        check(32'(n), 32'(nExp));
        for (int i = 0; i < nExp && i < n; i++)
            check(32'(seen[i]), 32'(e[i]));
        check({29'h0, driveCmd.run, busy, done}, 32'h1);
        $display("run m=%0d act=%0d lim=%0d steps=%0d", mc, a, l, n);
        @(posedge sys_clk) #DLY;
        controlWord = hss_pkg::CW_READY;
    endtask

    initial begin
        codes = '{hss_pkg::M_24, hss_pkg::M_26, hss_pkg::M_28, hss_pkg::M_29,
                  hss_pkg::M_30, hss_pkg::M_33, hss_pkg::M_34, hss_pkg::M_35};
        void'($urandom(32'h17A12C9B));
        repeat (2) @(posedge sys_clk);
        #DLY nrst = 1'h1;
        repeat (3) @(posedge sys_clk);
        // Unsupported code stays idle with an error
        startRun(8'($urandom % 24));
        check({29'h0, mErr, busy, driveCmd.run}, 32'h4);
        $display("run invalid code done");
        runCase(hss_pkg::M_24, 0, 0);
        runCase(hss_pkg::M_24, 0, 1);
        runCase(hss_pkg::M_24, 1, 0);
        runCase(hss_pkg::M_26, 0, 0);
        runCase(hss_pkg::M_26, 0, 1);
        runCase(hss_pkg::M_26, 1, 0);
        runCase(hss_pkg::M_28, 0, 0);
        runCase(hss_pkg::M_28, 0, 1);
        runCase(hss_pkg::M_28, 1, 0);
        runCase(hss_pkg::M_29, 0, 0);
        runCase(hss_pkg::M_29, 0, 1);
        runCase(hss_pkg::M_29, 1, 0);
        runCase(hss_pkg::M_30, 0, 0);
        runCase(hss_pkg::M_30, 0, 1);
        runCase(hss_pkg::M_30, 1, 0);
        runCase(hss_pkg::M_33, 0, 0);
        runCase(hss_pkg::M_34, 0, 0);
        runCase(hss_pkg::M_35, 0, 0);
        // Dropping run bit 3 mid-search aborts
        startRun(hss_pkg::M_26);
        repeat (10) @(posedge sys_clk);
        #DLY controlWord = 16'h0007;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check({29'h0, driveCmd.run, busy, done}, 32'h0);
        $display("run abort done");
        for (int r = 0; r < 24; r++) begin
            m = codes[$urandom % 8];
            act = (m < hss_pkg::M_33) && ($urandom % 2 == 1);
            lim = (m < hss_pkg::M_33) && !act && ($urandom % 2 == 1);
            runCase(m, act, lim);
        end
        endOfTest();
    end
endmodule
